/* File: rtl/pmc_cfg.svh */
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
// Full-scale count of one measurement window
`define PMC_FULL_SCALE 4000
// Input-clock periods in one conversion cycle
`define PMC_CONV_CYCLES 129024
// Least periods from a transfer request to result ready
`define PMC_MIN_DELAY 512
// Periods that result ready stays high in free-running operation
`define PMC_HOLD_CYCLES 128
// Width of the conversion count
`define PMC_RESULT_W 12
// Width of the timebase phase counter
`define PMC_PHASE_W 17
// Width of the request age and hold counters
`define PMC_AGE_W 10
// Reset value of the counts and of the display latch
`define PMC_COUNT_RST 12'h000
`endif

/* File: rtl/pmc_pkg.sv */
`include "pmc_cfg.svh"
package pmc_pkg;
   // Conversion count as held by accumulator, result and display latch
   typedef logic [`PMC_RESULT_W-1:0] pmc_count_t;
   // Transfer handshake states, one-hot
   typedef enum logic [3:0]
   {
      HS_PEND = 4'h1, // Request latched, result ready low
      HS_HOLD = 4'h2, // Fresh transfer, result ready high and counted
      HS_SHOW = 4'h4, // Result ready high until the next request
      HS_FREE = 4'h8 // Free-running, waiting for the next cycle end
   } pmc_hs_state_t;
endpackage

/* File: rtl/pmc_sampler.sv */
`timescale 1ns/1ns
module pmc_sampler (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic resetn_in,
   // Comparator decision and its sampled state
   input wire logic comparator_in,
   output logic sample_out
);
   logic sample_reg; // Sampling flip-flop state

   // Comparator into the data input, taken on each rising edge
   always_ff @(posedge core_clk_in)
   begin
      if (!resetn_in)
         sample_reg <= 1'b0;
      else
         sample_reg <= comparator_in;
   end

   // State drives the reference switch and the pulse gate
   assign sample_out = sample_reg;

   // Sampled state is last cycle's comparator level
   sample_track_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      ##1 (sample_out == $past(comparator_in)))
      else $error("sampler lost the comparator level");
endmodule

/* File: rtl/pmc_timebase.sv */
`timescale 1ns/1ns
`include "pmc_cfg.svh"
module pmc_timebase #(
   parameter int CONV_CYCLES = `PMC_CONV_CYCLES,
   parameter int FULL_SCALE = `PMC_FULL_SCALE
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic resetn_in,
   // Window and cycle markers
   output logic in_window_out,
   output logic win_end_out,
   output logic slot_out
);
   localparam int W = `PMC_PHASE_W;
   localparam logic [W-1:0] LAST = W'(CONV_CYCLES - 1); // Last phase of a cycle
   localparam logic [W-1:0] WIN_LAST = W'(FULL_SCALE - 1); // Last phase of the window
   logic [W-1:0] phase_reg; // Position in the conversion cycle
   logic [W-1:0] phase_next;

   // Free-running wrap counter, never touched by the handshake
   assign phase_next = (phase_reg == LAST) ? '0 : phase_reg + W'(1);
   // Window covers the first full-scale phases of each cycle
   assign in_window_out = (phase_reg <= WIN_LAST);
   assign win_end_out = (phase_reg == WIN_LAST);
   assign slot_out = (phase_reg == LAST);

   // Phase register
   always_ff @(posedge core_clk_in)
   begin
      if (!resetn_in)
         phase_reg <= '0;
      else
         phase_reg <= phase_next;
   end

   // A new window opens right after each cycle end
   window_open_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      slot_out |=> (in_window_out && !slot_out && !win_end_out) [*8])
      else $error("window did not open after the cycle end");
endmodule

/* File: rtl/pmc_top.sv */
`timescale 1ns/1ns
`include "pmc_cfg.svh"
module pmc_top #(
   parameter int CONV_CYCLES = `PMC_CONV_CYCLES, // Periods per conversion cycle
   parameter int FULL_SCALE = `PMC_FULL_SCALE, // Window length in periods
   parameter int MIN_DELAY = `PMC_MIN_DELAY, // Least request to ready delay
   parameter int HOLD_CYCLES = `PMC_HOLD_CYCLES // Free-running ready high time
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic resetn_in,
   // Analog loop
   input wire logic comparator_in,
   output logic reference_switch_out,
   // Transfer handshake
   input wire logic xfer_req_in,
   output logic result_ready_out,
   output pmc_pkg::pmc_count_t display_out
);
   import pmc_pkg::*;

   localparam int AW = `PMC_AGE_W;
   localparam int GW = `PMC_PHASE_W + 1;
   localparam logic [AW-1:0] AGE_LAST = AW'(MIN_DELAY - 1); // Age at which a request is ripe
   localparam logic [AW-1:0] HOLD_LAST = AW'(HOLD_CYCLES - 1); // Last held cycle
   localparam logic [GW-1:0] GAP_MAX = '1; // Saturation of the gap and wait watch counters

   // Analog loop and timebase
   logic sample_q; // Duty-cycle state of the sampling flip-flop
   logic in_window; // Timebase window open
   logic win_end; // Last period of the window
   logic slot; // Last period of the conversion cycle
   logic count_en; // Gated clock pulse
   // Accumulator and result
   pmc_count_t acc_reg, acc_next, acc_sum;
   pmc_count_t result_reg, result_next;
   pmc_count_t display_reg, display_next;
   // Handshake
   pmc_hs_state_t state_reg, state_next;
   logic req_prev_reg; // Request level one cycle back
   logic req_edge; // Request rising edge, sets the request latch
   logic fresh_reg, fresh_next; // A completed conversion awaits transfer
   logic [AW-1:0] age_reg, age_next; // Periods since the last request edge
   logic [AW-1:0] hold_reg, hold_next; // Periods spent in the hold state
   logic age_done; // Request old enough to be served
   logic xfer_go; // Copy result into the display latch this cycle
   logic ready_reg, ready_next;

   // Saturating up-count shared by the age and hold counters
   function automatic logic [AW-1:0] count_up(input logic [AW-1:0] v, input logic [AW-1:0] lim);
      count_up = (v >= lim) ? v : v + AW'(1);
   endfunction

   // Comparator sampling flip-flop
   pmc_sampler u_sampler (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .comparator_in(comparator_in),
      .sample_out(sample_q)
   );

   // Reference switch is the flip-flop output itself
   assign reference_switch_out = sample_q;

   // Measurement window and cycle end markers
   pmc_timebase #(
      .CONV_CYCLES(CONV_CYCLES),
      .FULL_SCALE(FULL_SCALE)
   ) u_timebase (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .in_window_out(in_window),
      .win_end_out(win_end),
      .slot_out(slot)
   );

   // Gate: a clock pulse counts only while the duty state is high
   assign count_en = sample_q & in_window;
   assign acc_sum = acc_reg + pmc_count_t'(count_en);
   // Window end restarts the accumulator from zero
   assign acc_next = win_end ? `PMC_COUNT_RST : acc_sum;
   // Completed count, independent of the handshake
   assign result_next = win_end ? acc_sum : result_reg;

   // Request latch set on the rising edge of the request
   assign req_edge = xfer_req_in & ~req_prev_reg;
   assign age_done = (age_reg >= AGE_LAST);
   assign age_next = req_edge ? '0 : count_up(age_reg, AGE_LAST);

   // Transfer only with a completed conversion; a new edge defers it
   always_comb
   begin
      xfer_go = 1'b0;
      case (state_reg)
         HS_PEND: xfer_go = (fresh_reg | slot) & age_done & ~req_edge;
         HS_FREE: xfer_go = (fresh_reg | slot) & xfer_req_in & ~req_edge;
         default: xfer_go = 1'b0;
      endcase
   end

   // Fresh flag: cycle end sets, transfer consumes, request edge drops stale
   assign fresh_next = (slot & ~xfer_go) | (fresh_reg & ~xfer_go & ~req_edge);

   // Handshake state machine
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         // Waiting for the next completed conversion
         HS_PEND:
         begin
            if (xfer_go)
               state_next = HS_HOLD;
         end
         // Counting the high time after a transfer
         HS_HOLD:
         begin
            if (req_edge)
               state_next = HS_PEND;
            else if (hold_reg >= HOLD_LAST)
               state_next = xfer_req_in ? HS_FREE : HS_SHOW;
         end
         // Result shown until the host asks again
         HS_SHOW:
         begin
            if (req_edge)
               state_next = HS_PEND;
         end
         // Free-running, next transfer at the cycle end
         HS_FREE:
         begin
            if (req_edge)
               state_next = HS_PEND;
            else if (xfer_go)
               state_next = HS_HOLD;
         end
         default: state_next = HS_FREE;
      endcase
   end

   // Hold counter runs only while staying in the hold state
   assign hold_next = ((state_reg == HS_HOLD) && (state_next == HS_HOLD)) ?
      count_up(hold_reg, HOLD_LAST) : '0;
   // Ready high in the hold and show states only
   assign ready_next = (state_next == HS_HOLD) || (state_next == HS_SHOW);
   // Display latch written only by a transfer
   assign display_next = xfer_go ? result_reg : display_reg;

   // Accumulator and result registers
   always_ff @(posedge core_clk_in)
   begin
      if (!resetn_in)
      begin
         acc_reg <= `PMC_COUNT_RST;
         result_reg <= `PMC_COUNT_RST;
      end
      else
      begin
         acc_reg <= acc_next;
         result_reg <= result_next;
      end
   end

   // Handshake registers
   always_ff @(posedge core_clk_in)
   begin
      if (!resetn_in)
      begin
         state_reg <= HS_FREE;
         req_prev_reg <= 1'b0;
         fresh_reg <= 1'b0;
         age_reg <= '0;
         hold_reg <= '0;
         ready_reg <= 1'b0;
         display_reg <= `PMC_COUNT_RST;
      end
      else
      begin
         state_reg <= state_next;
         req_prev_reg <= xfer_req_in;
         fresh_reg <= fresh_next;
         age_reg <= age_next;
         hold_reg <= hold_next;
         ready_reg <= ready_next;
         display_reg <= display_next;
      end
   end

   // Outputs straight from flip-flops
   assign result_ready_out = ready_reg;
   assign display_out = display_reg;

   // Watch logic for the checks below
   logic ready_prev_reg, prev_pend_reg, prev_free_reg, last_free_reg;
   logic [GW-1:0] gap_reg, wait_reg;
   logic [AW-1:0] hi_reg;
   logic ready_rise;
   assign ready_rise = ready_reg & ~ready_prev_reg;

   // Gap between rises, wait since request, high time
   always_ff @(posedge core_clk_in)
   begin
      if (!resetn_in)
      begin
         ready_prev_reg <= 1'b0;
         prev_pend_reg <= 1'b0;
         prev_free_reg <= 1'b0;
         last_free_reg <= 1'b0;
         gap_reg <= '0;
         wait_reg <= '0;
         hi_reg <= '0;
      end
      else
      begin
         ready_prev_reg <= ready_reg;
         prev_pend_reg <= (state_reg == HS_PEND);
         prev_free_reg <= (state_reg == HS_FREE);
         last_free_reg <= ready_rise ? prev_free_reg : last_free_reg;
         gap_reg <= ready_rise ? GW'(1) : ((gap_reg == GAP_MAX) ? gap_reg : gap_reg + GW'(1));
         wait_reg <= req_edge ? GW'(1) : ((wait_reg == GAP_MAX) ? wait_reg : wait_reg + GW'(1));
         hi_reg <= ready_reg ? hi_reg + AW'(1) : '0;
      end
   end

   // Request edge followed by a low ready in the pending state
   sequence req_seen_s;
      req_edge;
   endsequence
   sequence ready_dropped_s;
      !result_ready_out && (state_reg == HS_PEND);
   endsequence
   property req_drop_p;
      @(posedge core_clk_in) disable iff (!resetn_in) req_seen_s |=> ready_dropped_s;
   endproperty
   req_drop_a: assert property (req_drop_p)
      else $error("ready not dropped after a request edge");

   // Accumulator adds one per gated pulse inside the window
   acc_count_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      (in_window && !win_end) |=> (acc_reg == $past(acc_reg) + pmc_count_t'($past(sample_q))))
      else $error("accumulator missed a gated pulse");

   // Window end clears the accumulator and keeps the full count
   acc_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      win_end |=> (acc_reg == `PMC_COUNT_RST) && (result_reg <= pmc_count_t'(FULL_SCALE)))
      else $error("accumulator not cleared at window end");

   // Latch written with the result, ready rising at the same edge
   latch_write_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      xfer_go |=> result_ready_out && !$past(result_ready_out) &&
      (display_out == $past(result_reg)))
      else $error("latch write without a ready rise");

   // Latch contents change only together with a ready rise
   latch_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      !$rose(result_ready_out) |-> $stable(display_out))
      else $error("display latch changed without a ready rise");

   // Request to ready delay bounded on both sides; the wait count runs one ahead
   req_delay_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      (ready_rise && prev_pend_reg) |->
      (wait_reg > GW'(MIN_DELAY)) && (wait_reg <= GW'(CONV_CYCLES)))
      else $error("request to ready delay out of range");

   // Free-running rises exactly one conversion cycle apart
   free_period_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      (ready_rise && prev_free_reg && last_free_reg) |-> (gap_reg == GW'(CONV_CYCLES)))
      else $error("free-running update period wrong");

   // Free-running ready falls after exactly the hold time
   free_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      ($fell(result_ready_out) && !$past(req_edge) && (state_reg == HS_FREE)) |->
      (hi_reg == AW'(HOLD_CYCLES)))
      else $error("free-running ready high time wrong");

   // One update per request: hold follows, no immediate second transfer
   one_update_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      ($rose(result_ready_out) && !req_edge) |-> (state_reg == HS_HOLD) ##1 !xfer_go)
      else $error("request latch not cleared by its transfer");

   // Cycle end yields a fresh result unless a transfer takes it in the same cycle
   loop_indep_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      (slot && !xfer_go) |=> fresh_reg)
      else $error("conversion result lost at cycle end");
endmodule

/* File: sim/pmc_loop_model.sv */
`timescale 1ns/1ns
// Behavioural stand-in for the analog filter and comparator around the block
module pmc_loop_model #(
   parameter int FULL_SCALE = 400
) (
   // Clock
   input wire logic core_clk_in,
   // Loop signals
   input wire logic reference_switch_in,
   input wire logic [11:0] level_in,
   output logic comparator_out = 1'b0
);
   int err_reg = 0; // Integrated difference between input and feedback
   int err_next; // Next integrated difference

   // Feedback pulls the error down only while the reference is selected
   assign err_next = err_reg + int'(level_in) - ((reference_switch_in === 1'b1) ? FULL_SCALE : 0);

   // Comparator goes high while the feedback lags the input level
   always @(posedge core_clk_in)
   begin
      err_reg <= err_next;
      comparator_out <= (err_next > 0);
   end
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ns
module testbench;
   import pmc_pkg::*;
   localparam int CONV = 1200; // Shortened conversion cycle
   localparam int FS = 400; // Shortened full scale
   localparam int MIN = 64; // Shortened least request delay
   localparam int HOLD = 16; // Shortened free-running ready time
   logic core_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic xfer_req_in = 1'b0;
   logic comparator_in;
   logic reference_switch_out;
   logic result_ready_out;
   pmc_count_t display_out;
   logic [11:0] level = 12'h000; // Analog input level in counts
   logic comp_prev = 1'b0; // Comparator as seen at the last edge
   logic run_prev = 1'b0; // Reset released at the last edge
   int miscompares = 0;
   int tests_run = 0;

   // Device under test with shortened counts
   pmc_top #(.CONV_CYCLES(CONV), .FULL_SCALE(FS), .MIN_DELAY(MIN), .HOLD_CYCLES(HOLD)) pmc_top_i (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .comparator_in(comparator_in),
      .reference_switch_out(reference_switch_out),
      .xfer_req_in(xfer_req_in),
      .result_ready_out(result_ready_out),
      .display_out(display_out)
   );

   // Analog loop; the host here never looks at a polarity level
   pmc_loop_model #(.FULL_SCALE(FS)) pmc_loop_model_i (
      .core_clk_in(core_clk_in),
      .reference_switch_in(reference_switch_out),
      .level_in(level),
      .comparator_out(comparator_in)
   );

   // Clock generator
   initial
   begin
      forever #5 core_clk_in = ~core_clk_in;
   end

   // Exact comparison with report
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Comparison with a small tolerance for quantisation
   task automatic check_near(input string what, input int exp, input pmc_count_t got);
      tests_run++;
      if ($isunknown(got) || int'(got) > exp + 2 || int'(got) + 2 < exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Waits for a ready level, returns edges waited, bounded
   task automatic wait_ready(input logic lvl, output int n);
      n = 0;
      do
      begin
         @(posedge core_clk_in);
         #1;
         n++;
      end
      while (result_ready_out !== lvl && n < 3000);
      check("ready wait", lvl, result_ready_out);
   endtask

   // Finds a free-running rise: one that follows a low spell of CONV-HOLD
   task automatic sync_free;
      int n;
      int m;
      int tries;
      tries = 0;
      do
      begin
         wait_ready(1'b0, n);
         wait_ready(1'b1, m);
         tries++;
      end
      while (m != CONV - HOLD && tries < 5);
      check("free low spell", CONV - HOLD, m);
   endtask

   // Reference switch follows the comparator one edge later
   always @(posedge core_clk_in)
   begin
      comp_prev <= comparator_in;
      run_prev <= resetn_in;
   end
   always @(negedge core_clk_in)
   begin
      if (run_prev)
         check("reference switch", comp_prev, reference_switch_out);
   end

   // Outputs are cleared during and just after reset
   task automatic t_reset;
      repeat (20) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      #1;
      check("reset ready", 0, result_ready_out);
      check("reset display", 0, display_out);
      check("reset switch", 0, reference_switch_out);
      $display("t_reset done");
   endtask

   // Free-running: count, hold time and period
   task automatic t_free(input logic [11:0] lvl);
      int n;
      @(posedge core_clk_in);
      level <= lvl;
      xfer_req_in <= 1'b1;
      sync_free;
      check_near("free display", int'(lvl), display_out);
      wait_ready(1'b0, n);
      check("free high time", HOLD, n);
      wait_ready(1'b1, n);
      check("free period", CONV, n + HOLD);
      $display("t_free done");
   endtask

   // Request k edges after a free rise, expect a fixed delay, then a held latch
   task automatic t_delay(input int k, input int expd, input logic [11:0] lvl);
      int m;
      pmc_count_t snap;
      logic held;
      @(posedge core_clk_in);
      level <= lvl;
      xfer_req_in <= 1'b1;
      sync_free;
      @(posedge core_clk_in);
      xfer_req_in <= 1'b0;
      repeat (k - 1) @(posedge core_clk_in);
      xfer_req_in <= 1'b1;
      // Ready still high here: only the next edge takes the request
      #1;
      check("ready before request", 1, result_ready_out);
      @(posedge core_clk_in);
      xfer_req_in <= 1'b0;
      #1;
      check("ready drop at take", 0, result_ready_out);
      @(posedge core_clk_in);
      #1;
      check("ready drop", 0, result_ready_out);
      wait_ready(1'b1, m);
      check("request delay", expd, m + 1);
      check_near("request display", int'(lvl), display_out);
      snap = display_out;
      held = 1'b1;
      repeat (2 * CONV + 100)
      begin
         @(posedge core_clk_in);
         #1;
         held = held & (result_ready_out === 1'b1) & (display_out === snap);
      end
      check("ready and latch held", 1, held);
      $display("t_delay done");
   endtask

   // Prints counts and verdict, ends the run
   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial
   begin
      t_reset;
      t_free(12'h0C8);
      t_delay(CONV - 5, MIN, 12'h000);
      t_delay(CONV + 3, CONV - 4, 12'h190);
      print_verdict;
   end

   // Watchdog, well beyond the expected run of about 16000 cycles
   initial
   begin
      #1000000;
      miscompares++;
      $display("[FAIL] watchdog expected finish seen hang");
      print_verdict;
   end
endmodule
